/* ac_ctrl_pkg.sv */
// constants for the analog comparator control block
package ac_ctrl_pkg;
  // register offsets (byte wide registers)
  localparam logic [2:0] OFF_COMP_CTRL   = 3'h0;
  localparam logic [2:0] OFF_INSEL_CTRL  = 3'h2;
  localparam logic [2:0] OFF_IRQEN_CTRL  = 3'h6;
  localparam logic [2:0] OFF_STATUS      = 3'h7;
  // comparator_control fields
  localparam int CTL_ENABLE_BIT   = 0;
  localparam int CTL_HYS_LSB      = 1;
  localparam int CTL_LP_BIT       = 3;
  localparam int CTL_EDGE_LSB     = 4;
  localparam int CTL_PIN_EN_BIT   = 6;
  localparam int CTL_STBY_RUN_BIT = 7;
  // input_select_control fields
  localparam int INS_NEG_LSB      = 0;
  localparam int INS_POS_BIT      = 3;
  localparam int INS_INVERT_BIT   = 7;
  // status fields
  localparam int STA_FLAG_BIT     = 0;
  localparam int STA_STATE_BIT    = 4;
  // reset values
  localparam logic [7:0] RST_COMP_CTRL  = 8'h00;
  localparam logic [7:0] RST_INSEL_CTRL = 8'h00;
  localparam logic [7:0] RST_IRQEN_CTRL = 8'h00;
  // interrupt edge encodings
  localparam logic [1:0] EDGE_BOTH = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_RISE = 2'h3;
  // settle times and clock
  localparam int CLK_MHZ       = 250;
  localparam int START_NS      = 2500;
  localparam int REF_START_NS  = 60000;
  localparam int START_CYC     = (START_NS * CLK_MHZ + 999) / 1000;
  localparam int REF_START_CYC = (REF_START_NS * CLK_MHZ + 999) / 1000;
  // sleep states and start-up sequencer states
  typedef enum logic [1:0] {
    SLP_ACTIVE = 2'b00,
    SLP_IDLE   = 2'b01,
    SLP_STBY   = 2'b10,
    SLP_PDOWN  = 2'b11
  } sleep_t;
  typedef enum logic [1:0] {
    ST_OFF    = 2'b00,
    ST_SETTLE = 2'b01,
    ST_RUN    = 2'b10
  } run_state_t;
endpackage : ac_ctrl_pkg

/* analog_comparator_control.sv */
// digital control and status wrapper around one analog comparator
//
// Notes on behaviour
// - result is one only when positive input exceeds negative input, else zero
// - positive mux picks one of two pins; negative picks two pins, dac, reference
// - hysteresis field selects off, 10mV, 25mV or 50mV
// - low power bit puts comparator in reduced current, slower mode
// - result invalid for 2.5us after enable, 60us when reference used
// - pin drive enable puts the result on the output pin
// - while enabled the result is presented continuously as an event
// - single interrupt at vector 0x00 fires on selected result edges
// - selected edge sets the interrupt flag in status
// - request asserted while enable bit and flag are both one
// - request stays until software clears the flag
// - idle sleep leaves everything running unchanged
// - standby halts the comparator unless standby run is set
// - standby run keeps event, pin and state bit; edges set no flag or irq without clock
// - power down disables comparator and pin output
// - halted debug does not affect comparator operation
// - inversion applies before every consumer of the result
// - edge field: 0 both, 2 falling, 3 rising, 1 reserved
// - writing one to flag clears it, zero has no effect
// - state bit follows the result after three clock synchroniser delay
// - invert feeds pin, event, state bit and edge detection
`timescale 1ns/1ps
`default_nettype none
module analog_comparator_control
  import ac_ctrl_pkg::*;
#(
  parameter int START_CYCLES     = START_CYC,
  parameter int REF_START_CYCLES = REF_START_CYC
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  // register port
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // analog front end control and raw result
  input  wire logic       cmp_raw,
  output logic            cmp_power_on,
  output logic            cmp_low_power,
  output logic      [1:0] hysteresis_select,
  output logic            positive_input_select,
  output logic      [1:0] negative_input_select,
  output logic            ref_request,
  // system state
  input  wire logic [1:0] sleep_state,
  input  wire logic       per_clk_requested,
  input  wire logic       debug_halted,
  // results
  output logic            cmp_event,
  output logic            cmp_event_valid,
  output logic            cmp_pin_out,
  output logic            cmp_pin_oe_b,
  output logic            comparator_irq_vector
);

  localparam int CNT_W = $clog2(REF_START_CYCLES + 1);

  // reset copy
  logic             rst_s1_q;
  logic             rst_s2_q;
  logic             rst_n;

  // software registers
  logic [7:0]       ctrl_q;
  logic [7:0]       insel_q;
  logic             irq_en_q;
  logic [7:0]       rdata_q;

  // result path
  logic             sync1_q;
  logic             sync2_q;
  logic             sync3_q;
  logic             prev_q;
  logic             flag_q;
  logic             flag_d;
  logic             evt_q;
  logic             pin_q;

  // start-up sequencer
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  run_state_t       st_q;
  run_state_t       st_d;

  // reset release, first stage
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
    end
  end

  // reset release, second stage gives the internal reset
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s2_q <= 1'b0;
    end else begin
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_n = rst_s2_q;

  // decode
  wire wr_ctrl   = reg_wr && (reg_addr == OFF_COMP_CTRL);
  wire wr_insel  = reg_wr && (reg_addr == OFF_INSEL_CTRL);
  wire wr_irqen  = reg_wr && (reg_addr == OFF_IRQEN_CTRL);
  wire wr_status = reg_wr && (reg_addr == OFF_STATUS);

  // field views
  wire       enable_bit = ctrl_q[CTL_ENABLE_BIT];
  wire       stby_run   = ctrl_q[CTL_STBY_RUN_BIT];
  wire [1:0] edge_sel   = ctrl_q[CTL_EDGE_LSB +: 2];
  wire       invert     = insel_q[INS_INVERT_BIT];
  wire       uses_ref   = (insel_q[INS_NEG_LSB +: 2] == 2'h2) ||
                          (insel_q[INS_NEG_LSB +: 2] == 2'h3);

  // sleep gating; idle and debug halt never stop the block
  wire in_stby  = (sleep_state == SLP_STBY);
  wire in_pdown = (sleep_state == SLP_PDOWN);
  wire run_ok   = enable_bit && !in_pdown && !(in_stby && !stby_run);
  // edges stop setting the flag and interrupt in standby unless the clock is held up
  wire stat_ok  = !in_stby || per_clk_requested;

  // analog front end controls
  assign cmp_power_on          = run_ok;
  assign cmp_low_power         = ctrl_q[CTL_LP_BIT];
  assign hysteresis_select     = ctrl_q[CTL_HYS_LSB +: 2];
  assign positive_input_select = insel_q[INS_POS_BIT];
  assign negative_input_select = insel_q[INS_NEG_LSB +: 2];
  assign ref_request           = run_ok && uses_ref;

  // the result is untrusted while the comparator, and any internal reference, start up
  wire [CNT_W-1:0] start_load  = uses_ref ? CNT_W'(REF_START_CYCLES) : CNT_W'(START_CYCLES);
  wire             settle_done = (cnt_q <= CNT_W'(1));

  // startup settle counter
  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q;
    case (st_q)
      ST_OFF: begin
        if (run_ok) begin
          st_d  = ST_SETTLE;
          cnt_d = start_load;
        end
      end
      ST_SETTLE: begin
        if (!run_ok) begin
          st_d = ST_OFF;
        end else if (settle_done) begin
          st_d  = ST_RUN;
          cnt_d = '0;
        end else begin
          cnt_d = cnt_q - CNT_W'(1);
        end
      end
      ST_RUN: begin
        if (!run_ok) begin
          st_d = ST_OFF;
        end
      end
      default: begin
        st_d  = ST_OFF;
        cnt_d = '0;
      end
    endcase
  end

  wire valid = (st_q == ST_RUN);

  // result path; the raw pin is read by the first synchroniser flop only
  wire res_inv   = sync3_q ^ invert;
  wire rise      = res_inv && !prev_q;
  wire fall      = !res_inv && prev_q;
  // edges count only once the result is trusted and the status may change
  wire edge_gate = valid && stat_ok;
  wire want_both = (edge_sel == EDGE_BOTH);
  wire want_fall = (edge_sel == EDGE_FALL);
  wire want_rise = (edge_sel == EDGE_RISE);
  wire edge_hit  = edge_gate &&
                   ((want_both && (rise || fall)) ||
                    (want_fall && fall) ||
                    (want_rise && rise));
  wire clr_flag  = wr_status && reg_wdata[STA_FLAG_BIT];

  // set wins over clear, so an edge that meets a software clear
  // is never lost
  assign flag_d = edge_hit ? 1'b1 : (clr_flag ? 1'b0 : flag_q);

  // readback words; unimplemented bits and offsets read as zero
  wire [7:0] status_v = {3'b000, res_inv, 3'b000, flag_q};
  wire [7:0] insel_v  = {insel_q[7], 3'b000, insel_q[3], 1'b0, insel_q[1:0]};
  wire [7:0] irqen_v  = {7'b0000000, irq_en_q};
  wire       rd_ctrl  = (reg_addr == OFF_COMP_CTRL);
  wire       rd_insel = (reg_addr == OFF_INSEL_CTRL);
  wire       rd_irqen = (reg_addr == OFF_IRQEN_CTRL);
  wire       rd_stat  = (reg_addr == OFF_STATUS);
  wire [7:0] rd_mux   = ({8{rd_ctrl}}  & ctrl_q)  |
                        ({8{rd_insel}} & insel_v) |
                        ({8{rd_irqen}} & irqen_v) |
                        ({8{rd_stat}}  & status_v);

  // comparator_control: plain read/write byte
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= RST_COMP_CTRL;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= reg_wdata;
      end
    end
  end

  // input_select_control: unused bits are held at zero
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      insel_q <= RST_INSEL_CTRL;
    end else begin
      if (wr_insel) begin
        insel_q <= reg_wdata & 8'h8B;
      end
    end
  end

  // irq_enable_control: only bit zero exists
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_en_q <= RST_IRQEN_CTRL[0];
    end else begin
      if (wr_irqen) begin
        irq_en_q <= reg_wdata[0];
      end
    end
  end

  // first synchroniser stage: the only reader of the asynchronous result
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 1'b0;
    end else begin
      sync1_q <= cmp_raw;
    end
  end

  // second stage, read only by the third
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync2_q <= 1'b0;
    end else begin
      sync2_q <= sync1_q;
    end
  end

  // third stage completes the three cycle delay of the state bit
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync3_q <= 1'b0;
    end else begin
      sync3_q <= sync2_q;
    end
  end

  // previous result; it tracks even while untrusted so no false edge follows start-up
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= res_inv;
    end
  end

  // interrupt flag
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  // start-up sequencer state
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_OFF;
    end else begin
      st_q <= st_d;
    end
  end

  // settle counter
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // read data stand for one cycle after the strobe, zero otherwise
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // event output, low until the result is trusted
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_q <= 1'b0;
    end else begin
      evt_q <= valid && res_inv;
    end
  end

  // pin output carries the same value as the event
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= valid && res_inv;
    end
  end

  // register port
  assign reg_rdata             = rdata_q;

  // result outputs
  assign cmp_event             = evt_q;
  assign cmp_event_valid       = valid;
  assign cmp_pin_out           = pin_q;
  // pin enable is low while the pin is driven

  // interrupt request is a level from the registers
  assign cmp_pin_oe_b          = !(ctrl_q[CTL_PIN_EN_BIT] && !in_pdown);
  assign comparator_irq_vector = irq_en_q && flag_q;

endmodule : analog_comparator_control
`default_nettype wire

/* ac_ctrl_sva.sv */
// concurrent checks on the comparator wrapper ports
`timescale 1ns/1ps
`default_nettype none
module ac_ctrl_sva
  import ac_ctrl_pkg::*;
#(
  parameter int START_CYCLES     = 4,
  parameter int REF_START_CYCLES = 8
) (
  // watched ports
  input wire logic       sys_clk,
  input wire logic       rst_b,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic [1:0] sleep_state,
  input wire logic       per_clk_requested,
  input wire logic       cmp_power_on,
  input wire logic [1:0] negative_input_select,
  input wire logic       ref_request,
  input wire logic       cmp_event,
  input wire logic       cmp_event_valid,
  input wire logic       cmp_pin_out,
  input wire logic       cmp_pin_oe_b,
  input wire logic       comparator_irq_vector
);
  localparam int SLO = START_CYCLES - 1;
  localparam int SHI = START_CYCLES + 2;
  localparam int RLO = REF_START_CYCLES - 1;
  localparam int RHI = REF_START_CYCLES + 2;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence ctl_wr(b);
    reg_wr && reg_addr == OFF_COMP_CTRL && reg_wdata[CTL_ENABLE_BIT] == b;
  endsequence
  a_enable_powers: assert property (ctl_wr(1'b1) ##1 sleep_state == SLP_ACTIVE |-> cmp_power_on)
    else $error("enable write did not power the comparator");
  a_disable_unpowers: assert property (ctl_wr(1'b0) |=> !cmp_power_on)
    else $error("disable write left the comparator powered");
  a_ref_follows: assert property (ref_request == (cmp_power_on && negative_input_select[1]))
    else $error("reference request does not match selection");
  a_settle_plain: assert property ($rose(cmp_power_on) && !ref_request |->
    !cmp_event_valid ##[SLO:SHI] cmp_event_valid) else $error("plain start-up time wrong");
  a_settle_ref: assert property ($rose(cmp_power_on) && ref_request |->
    !cmp_event_valid ##[RLO:RHI] cmp_event_valid) else $error("reference start-up time wrong");
  a_pdown_off: assert property (sleep_state == SLP_PDOWN |-> cmp_pin_oe_b && !cmp_power_on)
    else $error("power-down left comparator or pin active");
  a_pin_matches: assert property (!cmp_pin_oe_b |-> cmp_pin_out == cmp_event)
    else $error("pin output differs from event");
  a_event_gated: assert property (!cmp_event_valid |=> !cmp_event && !cmp_pin_out)
    else $error("result shown before start-up");
  a_irq_holds: assert property (comparator_irq_vector && !reg_wr |=> comparator_irq_vector)
    else $error("interrupt request dropped by itself");
  a_stby_frozen: assert property (sleep_state == SLP_STBY && !per_clk_requested && !reg_wr
    |=> $stable(comparator_irq_vector)) else $error("interrupt changed in standby");
endmodule : ac_ctrl_sva
`default_nettype wire

/* analog_front_model.sv */
// behavioural front end: input muxes and the comparator itself
`timescale 1ns/1ps
`default_nettype none
module analog_front_model (
  // wrapper controls
  input  wire logic        power_on,
  input  wire logic        pos_sel,
  input  wire logic [1:0]  neg_sel,
  // levels in mV: pos0, pos1, neg0, neg1, reference, dac
  input  wire logic [59:0] levels,
  // raw result
  output logic             cmp_raw
);
  // pins are purely analog here; no digital input buffer is modelled
  wire logic [9:0] vp = levels[pos_sel*10 +: 10];
  wire logic [9:0] vn = levels[20 + neg_sel*10 +: 10];
  assign cmp_raw = power_on && (vp > vn);
endmodule : analog_front_model
`default_nettype wire

/* analog_comparator_control_tb_top.sv */
// self-checking bench for the comparator control wrapper
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module analog_comparator_control_tb_top;
  import ac_ctrl_pkg::*;
  logic sys_clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, per_clk_requested = 0;
  logic debug_halted = 0, cmp_raw, cmp_power_on, cmp_low_power, positive_input_select;
  logic ref_request, cmp_event, cmp_event_valid, cmp_pin_out, cmp_pin_oe_b;
  logic comparator_irq_vector, e, inv = 0;
  logic [1:0] sleep_state = 0, hysteresis_select, negative_input_select;
  logic [2:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0, reg_rdata, rd_v, d;
  logic [59:0] levels = 0;
  int error_cnt = 0, samples_checked = 0, cyc = 0;
  always #2 sys_clk = ~sys_clk;
  analog_comparator_control #(.START_CYCLES(4), .REF_START_CYCLES(8)) dut (.sys_clk, .rst_b,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cmp_raw, .cmp_power_on,
    .cmp_low_power, .hysteresis_select, .positive_input_select, .negative_input_select,
    .ref_request, .sleep_state, .per_clk_requested, .debug_halted, .cmp_event,
    .cmp_event_valid, .cmp_pin_out, .cmp_pin_oe_b, .comparator_irq_vector);
  analog_front_model afe (.power_on(cmp_power_on), .pos_sel(positive_input_select),
    .neg_sel(negative_input_select), .levels, .cmp_raw);
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  always @(posedge sys_clk) if (++cyc == 30000) begin
    error_cnt++;
    summarize();
  end
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 rd_v = reg_rdata;
  endtask : rd
  task automatic set_in(input logic v);
    @(posedge sys_clk);
    levels[9:0] <= v ? 10'h258 : 10'h190;
    levels[29:20] <= 10'h1F4;
  endtask : set_in
  task automatic settle();
    for (int i = 0; i < 60 && cmp_event_valid !== 1'b1; i++) @(posedge sys_clk);
    repeat (6) @(posedge sys_clk);
  endtask : settle
  function automatic logic [7:0] msk(input int a);
    return a == 0 ? 8'hFF : a == 2 ? 8'h8B : a == 6 ? 8'h01 : 8'h00;
  endfunction : msk
  function automatic logic hit(input int m, input int r);
    return m == 0 || (m == 2 && r == 0) || (m == 3 && r == 1);
  endfunction : hit
  function automatic logic [7:0] rst_exp(input int a);
    return a == 7 ? {3'h0, inv, 4'h0} : 8'h00;
  endfunction : rst_exp
  function automatic logic cmp_exp(input logic [2:0] k, input logic inv);
    return inv ^ (levels[k[2]*10 +: 10] > levels[20 + k[1:0]*10 +: 10]);
  endfunction : cmp_exp
  initial begin
    void'($urandom(32'h7E50));
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge sys_clk);
    for (int a = 0; a < 8; a++) begin
      rd(a[2:0]);
      `CHK("reset", rst_exp(a), rd_v)
      d = $urandom;
      if (a == 2) inv = d[7];
      if (a == 0) d[0] = 1'b0;
      wr(a[2:0], d);
      #1;
      if (a == 0) `CHK("lp_hys", d[3:1], {cmp_low_power, hysteresis_select})
      rd(a[2:0]);
      `CHK("readback", a == 7 ? rst_exp(a) : d & msk(a), rd_v)
    end
    $display("test registers done");
    for (int k = 0; k < 8; k++) begin
      @(posedge sys_clk);
      levels <= 60'({$urandom, $urandom});
      per_clk_requested <= $urandom;
      e = $urandom;
      wr(OFF_INSEL_CTRL, {e, 3'h0, k[2], 1'b0, k[1:0]});
      wr(OFF_COMP_CTRL, 8'h41);
      settle();
      e = cmp_exp(k[2:0], e);
      rd(OFF_STATUS);
      `CHK("state", e, rd_v[STA_STATE_BIT])
      `CHK("event", e, cmp_event)
      `CHK("pin", {e, 1'b0}, {cmp_pin_out, cmp_pin_oe_b})
      `CHK("sel", k[2:0], {positive_input_select, negative_input_select})
      `CHK("ref", k[1], ref_request)
      wr(OFF_COMP_CTRL, 8'h00);
    end
    $display("test inputs done");
    wr(OFF_INSEL_CTRL, 8'h00);
    wr(OFF_IRQEN_CTRL, 8'h01);
    for (int m = 0; m < 4; m++) begin
      set_in(1'b0);
      wr(OFF_COMP_CTRL, {2'h0, m[1:0], 4'h1});
      settle();
      wr(OFF_STATUS, 8'h01);
      for (int r = 1; r >= 0; r--) begin
        set_in(r[0]);
        repeat (8) @(posedge sys_clk);
        rd(OFF_STATUS);
        `CHK("flag", hit(m, r), rd_v[STA_FLAG_BIT])
        `CHK("irq", hit(m, r), comparator_irq_vector)
        wr(OFF_STATUS, 8'h00);
        #1;
        `CHK("irq_kept", hit(m, r), comparator_irq_vector)
        wr(OFF_STATUS, 8'h01);
        #1;
        `CHK("irq_clear", 1'b0, comparator_irq_vector)
      end
    end
    $display("test edges done");
    for (int s = 0; s < 8; s++) begin
      wr(OFF_COMP_CTRL, {s[2], 7'h41});
      settle();
      sleep_state <= s[1:0];
      debug_halted <= $urandom;
      per_clk_requested <= 1'b0;
      @(posedge sys_clk);
      #1;
      `CHK("power", s[1:0] < 2 || (s[1:0] == 2 && s[2]), cmp_power_on)
      `CHK("pin_oe", s[1:0] == 3, cmp_pin_oe_b)
      @(posedge sys_clk);
      sleep_state <= SLP_ACTIVE;
    end
    $display("test sleep done");
    summarize();
  end
endmodule : analog_comparator_control_tb_top
bind analog_comparator_control ac_ctrl_sva #(.START_CYCLES(START_CYCLES),
  .REF_START_CYCLES(REF_START_CYCLES)) sva (.sys_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
  .sleep_state, .per_clk_requested, .cmp_power_on, .negative_input_select, .ref_request,
  .cmp_event, .cmp_event_valid, .cmp_pin_out, .cmp_pin_oe_b, .comparator_irq_vector);
`default_nettype wire
